// ### rtl/ifpr_pkg.sv
// ifpr_pkg: register map, field positions and reset values of the
// interrupt flag, enable and priority bank.
// assumes a byte-wide register port with a three-bit register index.
package ifpr_pkg;

  localparam int          DW       = 8;
  localparam int          AW       = 3;
  localparam int          NSRC     = 13;
  localparam int          NCORE    = 5;

  // register indices on the register port
  localparam logic [2:0]  OFS_CORE = 3'h0;
  localparam logic [2:0]  OFS_EDGE = 3'h1;
  localparam logic [2:0]  OFS_EXT  = 3'h2;
  localparam logic [2:0]  OFS_PF1  = 3'h3;
  localparam logic [2:0]  OFS_RST  = 3'h4;

  // core_interrupt_control fields
  localparam int B_GHEN  = 7;
  localparam int B_PLEN  = 6;
  localparam int B_T0EN  = 5;
  localparam int B_I0EN  = 4;
  localparam int B_RBEN  = 3;
  localparam int B_T0FL  = 2;
  localparam int B_I0FL  = 1;
  localparam int B_RBFL  = 0;
  // edge_and_priority_control fields
  localparam int B_PUD   = 7;
  localparam int B_EDG0  = 6;
  localparam int B_EDG1  = 5;
  localparam int B_EDG2  = 4;
  localparam int B_T0PR  = 2;
  localparam int B_RBPR  = 0;
  // external_interrupt_control fields
  localparam int B_I2PR  = 7;
  localparam int B_I1PR  = 6;
  localparam int B_I2EN  = 4;
  localparam int B_I1EN  = 3;
  localparam int B_I2FL  = 1;
  localparam int B_I1FL  = 0;
  // peripheral_flags_one read-only fields
  localparam int B_RXFL  = 5;
  localparam int B_TXFL  = 4;
  // reset_control_register field
  localparam int B_PMEN  = 7;

  // source index: 0 tmr0, 1 pin0, 2 pin1, 3 pin2, 4 port change,
  // 5..12 peripheral flag bits 0..7
  localparam int S_T0    = 0;
  localparam int S_I0    = 1;
  localparam int S_I1    = 2;
  localparam int S_I2    = 3;
  localparam int S_RB    = 4;
  localparam int S_PF    = 5;

  // values after reset and the two vector addresses
  localparam logic [7:0]  RST_EDGE = 8'hF5;
  localparam logic [7:0]  RST_EXT  = 8'hC0;
  localparam logic [23:0] VEC_HIGH = 24'h000008;
  localparam logic [23:0] VEC_LOW  = 24'h000018;

endpackage

// ### rtl/ifpr_req.sv
// ifpr_req: forms the high and low priority requests from flags,
// enables, priorities and the global enables.
// assumes peripheral sources sit at index S_PF and above.
`timescale 1ns/100ps
`default_nettype none
module ifpr_req
  import ifpr_pkg::*;
(
  ifpr_req_if.arb rq
);
  logic [NSRC-1:0] act;
  logic [NSRC-1:0] pmask;
  logic            core_any, peri_any, hi_any, lo_any;

  // compatibility mode: one level, peripherals behind the second gate
  assign pmask    = {{(NSRC-S_PF){1'b1}}, {S_PF{1'b0}}};
  assign act      = rq.flag & rq.en;
  assign core_any = |(act & ~pmask);
  assign peri_any = |(act & pmask);
  assign hi_any   = |(act & rq.prio);
  assign lo_any   = |(act & ~rq.prio);
  // priority bits only matter in priority mode
  assign rq.hi = rq.pmen ? (rq.ghen & hi_any)
                         : (rq.ghen & (core_any | (rq.plen & peri_any)));
  assign rq.lo = rq.pmen & rq.ghen & rq.plen & lo_any; // high enable stops all
endmodule
`default_nettype wire

// ### rtl/ifpr_req_if.sv
// ifpr_req_if: carries the source vectors and global enables to the
// request combiner and brings the two requests back.
// assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface ifpr_req_if #(parameter int N = 13);
  logic [N-1:0] flag;
  logic [N-1:0] en;
  logic [N-1:0] prio;
  logic         ghen;
  logic         plen;
  logic         pmen;
  logic         hi;
  logic         lo;
  modport src (output flag, en, prio, ghen, plen, pmen, input hi, lo);
  modport arb (input flag, en, prio, ghen, plen, pmen, output hi, lo);
endinterface
`default_nettype wire

// ### rtl/ifpr_sync.sv
// ifpr_sync: three-stage synchroniser with agreement filter per bit.
// assumes inputs are asynchronous pins; output is a clean level.
`timescale 1ns/100ps
`default_nettype none
module ifpr_sync
  import ifpr_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, lvl_reg;
      // first stage feeds only the second, never the filter
      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          lvl_reg <= 1'b0;
        end else if (ce_i) begin
          s1_reg  <= pin_i[g];
          s2_reg  <= s1_reg;
          s3_reg  <= s2_reg;
          if (s2_reg == s3_reg) lvl_reg <= s3_reg; // change only on agree
        end
      end
      assign level_o[g] = lvl_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// ### rtl/ifpr_top.sv
// ifpr_top: interrupt flag, enable and priority register bank.
// assumes same-clock event pulses from timers and peripherals, async
// external and port pins, and a byte register port read one cycle late.
`timescale 1ns/100ps
`default_nettype none
module ifpr_top
  import ifpr_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          ce_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [DW-1:0] rdata_o,
  input  wire logic          tmr0_ovf_i,
  input  wire logic          tmr1_ovf_i,
  input  wire logic          tmr2_match_i,
  input  wire logic          ccp_event_i,
  input  wire logic          ccp_pwm_i,
  input  wire logic          sync_done_i,
  input  wire logic          conv_done_i,
  input  wire logic          par_rw_i,
  input  wire logic          rx_full_i,
  input  wire logic          tx_empty_i,
  input  wire logic [2:0]    ext_pin_i,
  input  wire logic [3:0]    upper_port_pins_i,
  input  wire logic          port_read_i,
  input  wire logic [7:0]    port_latch_i,
  input  wire logic [7:0]    periph_enable_i,
  input  wire logic [7:0]    periph_priority_i,
  input  wire logic          ack_i,
  input  wire logic          ack_high_i,
  output logic [7:0]         pullup_en_o,
  output logic               irq_high_o,
  output logic               irq_low_o,
  output logic [23:0]        vector_o
);

  logic [NSRC-1:0] flag_reg, flag_next, set_vec, wsel, wval;
  logic [NCORE-1:0] en_reg;
  logic [3:0]      prio_reg;
  logic [2:0]      edge_reg, pin_d_reg, pin_s, edge_hit;
  logic [3:0]      pb_s, pb_latch_reg;
  logic            ghen_reg, plen_reg, pmen_reg, pud_reg;
  logic            ghen_next, plen_next;
  logic            wr_core, wr_edge, wr_ext, wr_pf, wr_rst;
  logic            mismatch;
  logic [DW-1:0]   rd_core, rd_edge, rd_ext, rd_pf, rd_rst, rd_mux;
  logic [DW-1:0]   rdata_reg;
  logic [7:0]      pullup_reg;
  logic            irq_high_reg, irq_low_reg;
  logic [23:0]     vector_reg;

  ifpr_req_if #(.N(NSRC)) rq ();

  // pins cross into the clock domain through the filtered synchroniser
  ifpr_sync #(.W(3)) u_ext_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (ext_pin_i),
    .level_o   (pin_s)
  );

  ifpr_sync #(.W(4)) u_port_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (upper_port_pins_i),
    .level_o   (pb_s)
  );

  ifpr_req u_req (
    .rq (rq.arb)
  );

  // register write decode
  assign wr_core = wr_i && (addr_i == OFS_CORE);
  assign wr_edge = wr_i && (addr_i == OFS_EDGE);
  assign wr_ext  = wr_i && (addr_i == OFS_EXT);
  assign wr_pf   = wr_i && (addr_i == OFS_PF1);
  assign wr_rst  = wr_i && (addr_i == OFS_RST);

  // edge select per pin, one means rising
  assign edge_hit = (pin_s & ~pin_d_reg & edge_reg)
                  | (~pin_s & pin_d_reg & ~edge_reg);
  // mismatch holds until a port read retakes the snapshot
  assign mismatch = (pb_s != pb_latch_reg);

  // events per source; the flag ignores every enable
  assign set_vec[S_T0]     = tmr0_ovf_i;
  assign set_vec[S_I0]     = edge_hit[0];
  assign set_vec[S_I1]     = edge_hit[1];
  assign set_vec[S_I2]     = edge_hit[2];
  assign set_vec[S_RB]     = mismatch;
  assign set_vec[S_PF + 0] = tmr1_ovf_i;
  assign set_vec[S_PF + 1] = tmr2_match_i;
  assign set_vec[S_PF + 2] = ccp_event_i & ~ccp_pwm_i;
  assign set_vec[S_PF + 3] = sync_done_i;
  assign set_vec[S_PF + 4] = 1'b0;
  assign set_vec[S_PF + 5] = 1'b0;
  assign set_vec[S_PF + 6] = conv_done_i;
  assign set_vec[S_PF + 7] = par_rw_i;

  // which register bit a write reaches for each flag
  assign wsel[S_T0]  = wr_core;
  assign wsel[S_I0]  = wr_core;
  assign wsel[S_I1]  = wr_ext;
  assign wsel[S_I2]  = wr_ext;
  assign wsel[S_RB]  = wr_core;
  assign wsel[NSRC-1:S_PF] = {(NSRC-S_PF){wr_pf}};
  assign wval[S_T0]  = wdata_i[B_T0FL];
  assign wval[S_I0]  = wdata_i[B_I0FL];
  assign wval[S_I1]  = wdata_i[B_I1FL];
  assign wval[S_I2]  = wdata_i[B_I2FL];
  assign wval[S_RB]  = wdata_i[B_RBFL];
  assign wval[NSRC-1:S_PF] = wdata_i;

  // set wins over a clearing write in the same cycle
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_flag
      if (i == S_PF + B_RXFL) begin : g_rx
        assign flag_next[i] = rx_full_i;
      end else if (i == S_PF + B_TXFL) begin : g_tx
        assign flag_next[i] = tx_empty_i;
      end else begin : g_sticky
        assign flag_next[i] = set_vec[i]
                            | (wsel[i] ? wval[i] : flag_reg[i]);
      end
    end
  endgenerate

  // response clears the enable of the level that was taken
  assign ghen_next = (ack_i && (!pmen_reg || ack_high_i)) ? 1'b0
                   : (wr_core ? wdata_i[B_GHEN] : ghen_reg);
  assign plen_next = (ack_i && pmen_reg && !ack_high_i) ? 1'b0
                   : (wr_core ? wdata_i[B_PLEN] : plen_reg);

  // flags and pin history
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_reg     <= '0;
      pin_d_reg    <= '0;
      pb_latch_reg <= '0;
    end else if (ce_i) begin
      flag_reg  <= flag_next;
      pin_d_reg <= pin_s;
      if (port_read_i) pb_latch_reg <= pb_s;
    end
  end

  // global enables and mode bit
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ghen_reg <= 1'b0;
      plen_reg <= 1'b0;
      pmen_reg <= 1'b0;
    end else if (ce_i) begin
      ghen_reg <= ghen_next;
      plen_reg <= plen_next;
      if (wr_rst) pmen_reg <= wdata_i[B_PMEN];
    end
  end

  // per-source enables; only implemented bits are stored
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_reg <= '0;
    end else if (ce_i) begin
      if (wr_core) begin
        en_reg[S_T0] <= wdata_i[B_T0EN];
        en_reg[S_I0] <= wdata_i[B_I0EN];
        en_reg[S_RB] <= wdata_i[B_RBEN];
      end
      if (wr_ext) begin
        en_reg[S_I1] <= wdata_i[B_I1EN];
        en_reg[S_I2] <= wdata_i[B_I2EN];
      end
    end
  end

  // edge selects, pull-up disable and priorities
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pud_reg  <= RST_EDGE[B_PUD];
      edge_reg <= {RST_EDGE[B_EDG2], RST_EDGE[B_EDG1], RST_EDGE[B_EDG0]};
      prio_reg <= {RST_EDGE[B_RBPR], RST_EXT[B_I2PR], RST_EXT[B_I1PR],
                   RST_EDGE[B_T0PR]};
    end else if (ce_i) begin
      if (wr_edge) begin
        pud_reg     <= wdata_i[B_PUD];
        edge_reg    <= {wdata_i[B_EDG2], wdata_i[B_EDG1],
                        wdata_i[B_EDG0]};
        prio_reg[0] <= wdata_i[B_T0PR];
        prio_reg[3] <= wdata_i[B_RBPR];
      end
      if (wr_ext) begin
        prio_reg[1] <= wdata_i[B_I1PR];
        prio_reg[2] <= wdata_i[B_I2PR];
      end
    end
  end

  // request combiner inputs; pin 0 is always high priority
  assign rq.flag = flag_reg;
  assign rq.en   = {periph_enable_i, en_reg};
  assign rq.prio = {periph_priority_i, prio_reg[3], prio_reg[2],
                    prio_reg[1], 1'b1, prio_reg[0]};
  assign rq.ghen = ghen_reg;
  assign rq.plen = plen_reg;
  assign rq.pmen = pmen_reg;

  // read views; unimplemented positions are constant zero
  always_comb begin
    rd_core = '0;
    rd_core[B_GHEN] = ghen_reg;
    rd_core[B_PLEN] = plen_reg;
    rd_core[B_T0EN] = en_reg[S_T0];
    rd_core[B_I0EN] = en_reg[S_I0];
    rd_core[B_RBEN] = en_reg[S_RB];
    rd_core[B_T0FL] = flag_reg[S_T0];
    rd_core[B_I0FL] = flag_reg[S_I0];
    rd_core[B_RBFL] = flag_reg[S_RB];
  end

  always_comb begin
    rd_edge = '0;
    rd_edge[B_PUD]  = pud_reg;
    rd_edge[B_EDG0] = edge_reg[0];
    rd_edge[B_EDG1] = edge_reg[1];
    rd_edge[B_EDG2] = edge_reg[2];
    rd_edge[B_T0PR] = prio_reg[0];
    rd_edge[B_RBPR] = prio_reg[3];
  end

  always_comb begin
    rd_ext = '0;
    rd_ext[B_I2PR] = prio_reg[2];
    rd_ext[B_I1PR] = prio_reg[1];
    rd_ext[B_I2EN] = en_reg[S_I2];
    rd_ext[B_I1EN] = en_reg[S_I1];
    rd_ext[B_I2FL] = flag_reg[S_I2];
    rd_ext[B_I1FL] = flag_reg[S_I1];
  end

  always_comb begin
    rd_rst = '0;
    rd_rst[B_PMEN] = pmen_reg;
  end

  assign rd_pf  = flag_reg[NSRC-1:S_PF];
  assign rd_mux = (addr_i == OFS_CORE) ? rd_core
                : (addr_i == OFS_EDGE) ? rd_edge
                : (addr_i == OFS_EXT)  ? rd_ext
                : (addr_i == OFS_PF1)  ? rd_pf
                : (addr_i == OFS_RST)  ? rd_rst : 8'h00;

  // read data stands for the single cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) rdata_reg <= 8'h00;
    else if (ce_i) rdata_reg <= rd_i ? rd_mux : 8'h00;
  end

  // registered outputs to the core and the port pads
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_high_reg <= 1'b0;
      irq_low_reg  <= 1'b0;
      vector_reg   <= VEC_HIGH;
      pullup_reg   <= 8'h00;
    end else if (ce_i) begin
      irq_high_reg <= rq.hi;
      irq_low_reg  <= rq.lo;
      vector_reg   <= (pmen_reg && !rq.hi && rq.lo) ? VEC_LOW
                                                    : VEC_HIGH;
      pullup_reg   <= pud_reg ? 8'h00 : port_latch_i;
    end
  end

  assign rdata_o     = rdata_reg;
  assign irq_high_o  = irq_high_reg;
  assign irq_low_o   = irq_low_reg;
  assign vector_o    = vector_reg;
  assign pullup_en_o = pullup_reg;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_pin0_edge;
    ce_i && edge_hit[0];
  endsequence
  sequence s_ack_plain;
    ce_i && ack_i && !pmen_reg;
  endsequence

  a_flag_poll_set: assert property (
    ce_i && tmr0_ovf_i && !en_reg[S_T0] |=> flag_reg[S_T0])
    else $error("timer-0 flag not set while disabled");
  a_compat_block: assert property (
    ce_i && !pmen_reg && !ghen_reg |=> !irq_high_o && !irq_low_o)
    else $error("request while global enable clear");
  a_prio_high_req: assert property (
    ce_i && pmen_reg && ghen_reg && flag_reg[S_I0] && en_reg[S_I0]
    |=> irq_high_o)
    else $error("pin-0 high request missing");
  // peripheral sources may be pending; only core sources are ruled out
  a_periph_gate: assert property (
    ce_i && !pmen_reg && !plen_reg
    && ((flag_reg & rq.en & 13'h001F) == 13'h0000) |=> !irq_high_o)
    else $error("peripheral request passed closed gate");
  a_low_gate: assert property (
    ce_i && pmen_reg && !plen_reg |=> !irq_low_o)
    else $error("low request with low enable clear");
  a_flag_sticky: assert property (
    ce_i && flag_reg[S_T0] && !wr_core |=> flag_reg[S_T0])
    else $error("timer-0 flag dropped without write");
  a_edge_flag: assert property (
    s_pin0_edge |=> flag_reg[S_I0])
    else $error("pin-0 edge not flagged");
  a_mismatch_set: assert property (
    ce_i && mismatch && wr_core |=> flag_reg[S_RB])
    else $error("mismatch flag cleared during mismatch");
  a_pullup_off: assert property (
    ce_i && pud_reg |=> pullup_en_o == 8'h00)
    else $error("pull-ups on while disabled");
  a_reserved_zero: assert property (
    ce_i && rd_i && addr_i == OFS_EDGE |=> !rdata_o[3] && !rdata_o[1])
    else $error("unimplemented bit read nonzero");
  a_rx_mirror: assert property (
    ce_i && !rx_full_i |=> !flag_reg[S_PF + B_RXFL])
    else $error("receive flag set with empty buffer");
  a_pwm_ignore: assert property (
    ce_i && ccp_pwm_i && !wr_pf && !flag_reg[S_PF + 2]
    |=> !flag_reg[S_PF + 2])
    else $error("capture flag set in pwm mode");
  a_ack_clear: assert property (
    s_ack_plain |=> !ghen_reg ##1 (!irq_high_o || !ce_i || ghen_reg))
    else $error("global enable not cleared on response");
  a_vec_compat: assert property (
    ce_i && !pmen_reg |=> vector_o == VEC_HIGH)
    else $error("low vector in compatibility mode");

endmodule
`default_nettype wire

// ### verif/ifpr_core_model.sv
// ifpr_core_model: stands in for the processor core taking requests.
// assumes registered request levels on the shared clock.
`timescale 1ns/100ps
`default_nettype none
module ifpr_core_model (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic auto_i,
  input  wire logic irq_high_i,
  input  wire logic irq_low_i,
  output logic      ack_o,
  output logic      ack_high_o
);
  logic [2:0] wait_reg;

  // one-cycle answer, then a holdoff so a request that is still falling
  // after the enable clears is not answered twice
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_reg   <= 3'h0;
      ack_o      <= 1'b0;
      ack_high_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (wait_reg != 3'h0) begin
        wait_reg <= wait_reg - 3'h1;
      end else if (auto_i && (irq_high_i || irq_low_i)) begin
        ack_o      <= 1'b1;
        ack_high_o <= irq_high_i;
        wait_reg   <= 3'h4;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/interrupt_flag_enable_priority_tb.sv
// interrupt_flag_enable_priority_tb: self-checking bench for the bank.
// assumes a core model answering requests and one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module interrupt_flag_enable_priority_tb;
  import ifpr_pkg::*;
  logic        ref_clk_i;
  logic        nrst_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [2:0]  addr_i = 3'h0;
  logic [2:0]  ext_pin_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic [7:0]  port_latch_i = 8'h00;
  logic [7:0]  periph_enable_i = 8'h00;
  logic [7:0]  periph_priority_i = 8'hFF;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic        tmr0_ovf_i = 1'b0;
  logic        ccp_pwm_i = 1'b0;
  logic        rx_full_i = 1'b0;
  logic        tx_empty_i = 1'b1;
  logic [3:0]  upper_port_pins_i = 4'h0;
  logic        port_read_i = 1'b0;
  logic        auto_ack = 1'b0;
  logic        ack_i;
  logic        ack_high_i;
  logic [7:0]  rdata_o;
  logic [7:0]  pullup_en_o;
  logic        irq_high_o;
  logic        irq_low_o;
  logic [23:0] vector_o;
  int          errors = 0;
  int          checks_done = 0;

  // ev order: parallel, converter, sync serial, ccp, timer2, timer1
  ifpr_top uut (.ref_clk_i, .nrst_i, .ce_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .tmr0_ovf_i, .tmr1_ovf_i(ev[0]), .tmr2_match_i(ev[1]),
    .ccp_event_i(ev[2]), .ccp_pwm_i, .sync_done_i(ev[3]),
    .conv_done_i(ev[4]), .par_rw_i(ev[5]), .rx_full_i, .tx_empty_i,
    .ext_pin_i, .upper_port_pins_i, .port_read_i, .port_latch_i,
    .periph_enable_i, .periph_priority_i, .ack_i, .ack_high_i,
    .pullup_en_o, .irq_high_o, .irq_low_o, .vector_o);

  ifpr_core_model core (.ref_clk_i, .nrst_i, .auto_i(auto_ack),
    .irq_high_i(irq_high_o), .irq_low_i(irq_low_o), .ack_o(ack_i),
    .ack_high_o(ack_high_i));

  // free-running clock, 40 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic final_report;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // wait whole cycles; an output read at an edge shows what the edge
  // before it launched, so no settling delay is needed
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe rises an edge after the call, so back-to-back calls never
  // drive it twice in one time step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(rdata_o, e);
  endtask

  task automatic t_regs;
    rd(OFS_CORE, 8'h00);
    rd(OFS_EDGE, 8'hF5);
    rd(OFS_EXT, 8'hC0);
    rd(OFS_PF1, 8'h10);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    wr(OFS_EDGE, 8'h0A);
    rd(OFS_EDGE, 8'h00);
    port_latch_i <= 8'hA5;
    tick(2);
    chk(pullup_en_o, 8'hA5);
    wr(OFS_EDGE, 8'hF5);
    tick(2);
    chk(pullup_en_o, 8'h00);
    wr(OFS_EXT, 8'hFF);
    rd(OFS_EXT, 8'hDB);
    wr(OFS_EXT, 8'hC0);
  endtask

  task automatic t_compat;
    wr(OFS_EDGE, 8'hF1);
    tmr0_ovf_i <= 1'b1;
    tick(1);
    tmr0_ovf_i <= 1'b0;
    tick(1);
    rd(OFS_CORE, 8'h04);
    wr(OFS_CORE, 8'hA4);
    tick(2);
    chk(irq_high_o, 1'b1);
    chk(vector_o, 24'h000008);
    wr(OFS_CORE, 8'h24);
    tick(2);
    chk(irq_high_o, 1'b0);
    wr(OFS_CORE, 8'h00);
    periph_enable_i <= 8'h40;
    ev <= 6'h3F;
    tick(1);
    ev <= 6'h00;
    tick(1);
    rd(OFS_PF1, 8'hDF);
    wr(OFS_CORE, 8'h80);
    tick(2);
    chk(irq_high_o, 1'b0);
    wr(OFS_CORE, 8'hC0);
    tick(2);
    chk(irq_high_o, 1'b1);
    wr(OFS_CORE, 8'h00);
    wr(OFS_PF1, 8'h30);
    rd(OFS_PF1, 8'h10);
    ccp_pwm_i <= 1'b1;
    ev <= 6'h04;
    tick(1);
    ev <= 6'h00;
    tick(1);
    rd(OFS_PF1, 8'h10);
    ccp_pwm_i <= 1'b0;
    rx_full_i <= 1'b1;
    tx_empty_i <= 1'b0;
    tick(2);
    rd(OFS_PF1, 8'h20);
    rx_full_i <= 1'b0;
    tx_empty_i <= 1'b1;
    wr(OFS_EDGE, 8'hF5);
  endtask

  task automatic t_ack;
    auto_ack <= 1'b1;
    wr(OFS_CORE, 8'hA4);
    tick(8);
    rd(OFS_CORE, 8'h24);
    chk(irq_high_o, 1'b0);
    auto_ack <= 1'b0;
    wr(OFS_CORE, 8'h00);
  endtask

  task automatic t_prio;
    wr(OFS_RST, 8'hFF);
    rd(OFS_RST, 8'h80);
    wr(OFS_EDGE, 8'hF1);
    wr(OFS_CORE, 8'h64);
    tick(2);
    chk({irq_high_o, irq_low_o}, 2'b00);
    wr(OFS_CORE, 8'hE4);
    tick(2);
    chk({irq_high_o, irq_low_o}, 2'b01);
    chk(vector_o, 24'h000018);
    wr(OFS_EDGE, 8'hF5);
    tick(2);
    chk({irq_high_o, irq_low_o}, 2'b10);
    wr(OFS_CORE, 8'h00);
    wr(OFS_RST, 8'h00);
  endtask

  task automatic t_pins;
    ext_pin_i <= 3'b001;
    tick(8);
    rd(OFS_CORE, 8'h02);
    wr(OFS_EDGE, 8'hD5);
    ext_pin_i <= 3'b111;
    tick(8);
    rd(OFS_EXT, 8'hC2);
    ext_pin_i <= 3'b001;
    tick(8);
    rd(OFS_EXT, 8'hC3);
    wr(OFS_EXT, 8'hC0);
    wr(OFS_CORE, 8'h00);
    rd(OFS_CORE, 8'h00);
    wr(OFS_EDGE, 8'hF5);
  endtask

  task automatic t_port;
    upper_port_pins_i <= 4'h8;
    tick(8);
    rd(OFS_CORE, 8'h01);
    wr(OFS_CORE, 8'h00);
    rd(OFS_CORE, 8'h01);
    port_read_i <= 1'b1;
    tick(1);
    port_read_i <= 1'b0;
    wr(OFS_CORE, 8'h00);
    rd(OFS_CORE, 8'h00);
    // an overflow while the clock enable is low must leave no flag
    ce_i <= 1'b0;
    tmr0_ovf_i <= 1'b1;
    tick(1);
    ce_i <= 1'b1;
    tmr0_ovf_i <= 1'b0;
    rd(OFS_CORE, 8'h00);
  endtask

  // a hang costs far more than the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    tick(1);
    t_regs();
    t_compat();
    t_ack();
    t_prio();
    t_pins();
    t_port();
    final_report();
  end
endmodule
`default_nettype wire
